// >>> rtl/spvp_fifo.v
// Parameterised synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module spvp_fifo #(
    parameter WIDTH = 14,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_r;
    reg [AW-1:0] rd_r;
    reg [AW:0] cnt_r;
    wire push;
    wire pop;

    assign in_ready = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data = mem_r[rd_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge clk) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            wr_r <= {AW{1'b0}};
            rd_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_r <= wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= rd_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule // spvp_fifo

// >>> rtl/spvp_regs.vh
// Constants for the serial program/verify port: command codes, widths, addresses.
// Assumes inclusion by spvp_top.v, the test bench and the checker; spvp_fifo.v does not include it.
`ifndef SPVP_REGS_VH
`define SPVP_REGS_VH
`define SPVP_CMD_W 6
`define SPVP_DATA_W 14
`define SPVP_ADDR_W 14
`define SPVP_CMD_LOAD_CFG 6'h00
`define SPVP_CMD_LOAD_DATA 6'h02
`define SPVP_CMD_READ_DATA 6'h04
`define SPVP_CMD_INC_ADDR 6'h06
`define SPVP_CMD_BEGIN_PROG 6'h08
`define SPVP_ID_BASE 14'h2000
`define SPVP_ID_LAST 14'h2003
`define SPVP_ID_BITS 4
`define SPVP_PC_RESET 14'h0000
`define SPVP_FIFO_DEPTH 16
`endif

// >>> rtl/spvp_top.v
// Serial program/verify port: command/data shift engine toward program memory and ID words.
// Assumes pins come from outside MCLK domain; memory write side drains a FIFO and may stall.
`timescale 1ns/1ps
`include "spvp_regs.vh"

// Overview of operation
// - Program memory reads return real contents only while code protection is unprogrammed.
// - Four identification words live at addresses 2000h to 2003h.
// - The identification words are reachable only in program/verify mode.
// - Only the low four bits of each identification word are stored; upper bits read zero.
// - One pin is the serial clock and another the two-way serial data line, both filtered inputs.
// - On entry the program counter points to address zero.
// - A load is followed by 14 data bits in, a read by 14 data bits driven out.
module spvp_top (
    // Clock and reset
    input wire MCLK,
    input wire RST_N,
    // Programming pins
    input wire MASTER_CLEAR_HIGH,
    input wire PROG_CLOCK_PIN,
    input wire PROG_DATA_PIN_I,
    output reg PROG_DATA_PIN_O,
    output reg PROG_DATA_PIN_OE,
    // Mode and protection
    input wire CODE_PROTECT,
    output wire PROG_MODE,
    // Program memory write port
    output wire MEM_WR_VALID,
    input wire MEM_WR_READY,
    output wire [`SPVP_DATA_W-1:0] MEM_WR_DATA,
    output reg [`SPVP_ADDR_W-1:0] MEM_WR_ADDR,
    // Program memory read port
    output wire [`SPVP_ADDR_W-1:0] MEM_RD_ADDR,
    input wire [`SPVP_DATA_W-1:0] MEM_RD_DATA,
    // Status
    output wire BUSY
);
    localparam S_CMD = 4'b0001;
    localparam S_LOAD = 4'b0010;
    localparam S_READ = 4'b0100;
    localparam S_IDLE = 4'b1000;

    reg [2:0] clk_s_r;
    reg [1:0] dat_s_r;
    reg [1:0] hv_s_r;
    reg mode_r;
    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg [4:0] bit_r;
    reg [`SPVP_DATA_W-1:0] sh_r;
    reg [`SPVP_ADDR_W-1:0] pc_r;
    reg [`SPVP_DATA_W-1:0] load_r;
    reg [`SPVP_ID_BITS-1:0] id_r [0:3];
    reg prog_req_r;
    reg [`SPVP_ADDR_W-1:0] prog_addr_r;
    reg [`SPVP_DATA_W-1:0] prog_data_r;
    wire rise;
    wire fall;
    wire sdat;
    wire fifo_in_ready;
    wire is_id;
    reg [`SPVP_DATA_W-1:0] rd_word;

    function is_id_addr;
        input [`SPVP_ADDR_W-1:0] a;
        begin
            is_id_addr = (a >= `SPVP_ID_BASE) && (a <= `SPVP_ID_LAST);
        end
    endfunction

    always @(posedge MCLK) begin
        if (!RST_N) begin
            clk_s_r <= 3'h0;
            dat_s_r <= 2'h0;
            hv_s_r <= 2'h0;
        end else begin
            clk_s_r <= {clk_s_r[1:0], PROG_CLOCK_PIN};
            dat_s_r <= {dat_s_r[0], PROG_DATA_PIN_I};
            hv_s_r <= {hv_s_r[0], MASTER_CLEAR_HIGH};
        end
    end

    assign rise = clk_s_r[1] && !clk_s_r[2];
    assign fall = !clk_s_r[1] && clk_s_r[2];
    assign sdat = dat_s_r[1];
    assign PROG_MODE = mode_r;
    assign is_id = is_id_addr(pc_r);
    assign MEM_RD_ADDR = pc_r;
    assign BUSY = prog_req_r;

    always @* begin
        rd_word = {`SPVP_DATA_W{1'b0}};
        if (is_id) begin
            rd_word = {10'h000, id_r[pc_r[1:0]]};
        end else if (!CODE_PROTECT) begin
            rd_word = MEM_RD_DATA;
        end
    end

    always @* begin
        state_nxt = state_r;
        case (state_r)
            S_CMD: begin
                if (fall && bit_r == 5'd5) begin
                    case ({sdat, sh_r[`SPVP_DATA_W-1:`SPVP_DATA_W-5]})
                        `SPVP_CMD_LOAD_CFG: state_nxt = S_LOAD;
                        `SPVP_CMD_LOAD_DATA: state_nxt = S_LOAD;
                        `SPVP_CMD_READ_DATA: state_nxt = S_READ;
                        default: state_nxt = S_CMD;
                    endcase
                end
            end
            S_LOAD: begin
                if (fall && bit_r == 5'd13) begin
                    state_nxt = S_CMD;
                end
            end
            S_READ: begin
                if (fall && bit_r == 5'd13) begin
                    state_nxt = S_CMD;
                end
            end
            S_IDLE: state_nxt = S_IDLE;
            default: state_nxt = S_CMD;
        endcase
    end

    always @(posedge MCLK) begin
        if (!RST_N) begin
            mode_r <= 1'b0;
            state_r <= S_IDLE;
            bit_r <= 5'd0;
            sh_r <= {`SPVP_DATA_W{1'b0}};
            pc_r <= `SPVP_PC_RESET;
            load_r <= {`SPVP_DATA_W{1'b0}};
            PROG_DATA_PIN_O <= 1'b0;
            PROG_DATA_PIN_OE <= 1'b0;
            prog_req_r <= 1'b0;
            prog_addr_r <= {`SPVP_ADDR_W{1'b0}};
            prog_data_r <= {`SPVP_DATA_W{1'b0}};
            MEM_WR_ADDR <= {`SPVP_ADDR_W{1'b0}};
            id_r[0] <= 4'h0;
            id_r[1] <= 4'h0;
            id_r[2] <= 4'h0;
            id_r[3] <= 4'h0;
        end else if (!hv_s_r[1]) begin
            // Leaving the mode idles the engine, releases the data line and cancels a pending request
            mode_r <= 1'b0;
            state_r <= S_IDLE;
            PROG_DATA_PIN_OE <= 1'b0;
            prog_req_r <= 1'b0;
        end else if (!mode_r) begin
            // Enter only with clock and data low while master clear is high
            if (!clk_s_r[1] && !sdat) begin
                mode_r <= 1'b1;
                state_r <= S_CMD;
                bit_r <= 5'd0;
                pc_r <= `SPVP_PC_RESET;
            end
        end else begin
            state_r <= state_nxt;
            if (prog_req_r && fifo_in_ready) begin
                prog_req_r <= 1'b0;
            end
            // Drive on rising edge during a read
            if (rise && state_r == S_READ) begin
                PROG_DATA_PIN_OE <= 1'b1;
                PROG_DATA_PIN_O <= (bit_r == 5'd0) ? rd_word[0] : sh_r[0];
                if (bit_r == 5'd0) begin
                    sh_r <= {1'b0, rd_word[`SPVP_DATA_W-1:1]};
                end else begin
                    sh_r <= {1'b0, sh_r[`SPVP_DATA_W-1:1]};
                end
            end
            // Sample on falling edge, LSB first
            if (fall) begin
                case (state_r)
                    S_CMD: begin
                        sh_r <= {sdat, sh_r[`SPVP_DATA_W-1:1]};
                        if (bit_r == 5'd5) begin
                            bit_r <= 5'd0;
                            case ({sdat, sh_r[`SPVP_DATA_W-1:`SPVP_DATA_W-5]})
                                `SPVP_CMD_LOAD_CFG: pc_r <= `SPVP_ID_BASE;
                                `SPVP_CMD_INC_ADDR: pc_r <= pc_r + 14'h0001;
                                `SPVP_CMD_BEGIN_PROG: begin
                                    if (!prog_req_r) begin
                                        if (is_id) begin
                                            id_r[pc_r[1:0]] <= load_r[`SPVP_ID_BITS-1:0];
                                        end else begin
                                            prog_req_r <= 1'b1;
                                            prog_addr_r <= pc_r;
                                            prog_data_r <= load_r;
                                        end
                                    end
                                end
                                default: pc_r <= pc_r;
                            endcase
                        end else begin
                            bit_r <= bit_r + 5'd1;
                        end
                    end
                    S_LOAD: begin
                        sh_r <= {sdat, sh_r[`SPVP_DATA_W-1:1]};
                        if (bit_r == 5'd13) begin
                            bit_r <= 5'd0;
                            load_r <= {sdat, sh_r[`SPVP_DATA_W-1:1]};
                        end else begin
                            bit_r <= bit_r + 5'd1;
                        end
                    end
                    S_READ: begin
                        if (bit_r == 5'd13) begin
                            bit_r <= 5'd0;
                            PROG_DATA_PIN_OE <= 1'b0;
                        end else begin
                            bit_r <= bit_r + 5'd1;
                        end
                    end
                    default: bit_r <= 5'd0;
                endcase
            end
            if (prog_req_r && fifo_in_ready) begin
                MEM_WR_ADDR <= prog_addr_r;
            end
        end
    end

    // Write data passes a FIFO; address travels alongside the latest push
    spvp_fifo #(
        .WIDTH(`SPVP_DATA_W),
        .DEPTH(`SPVP_FIFO_DEPTH),
        .AW(4)
    ) u_fifo (
        .clk(MCLK),
        .rst_n(RST_N),
        .in_valid(prog_req_r),
        .in_ready(fifo_in_ready),
        .in_data(prog_data_r),
        .out_valid(MEM_WR_VALID),
        .out_ready(MEM_WR_READY),
        .out_data(MEM_WR_DATA)
    );
endmodule // spvp_top

// >>> verification/serial_program_verify_port_test.sv
// Self-checking bench: programmer model, stub memory, stalled write side.
// Assumes spvp_checker is bound in and the link clock comes from the model.
`timescale 1ns/1ps
`include "spvp_regs.vh"
module serial_program_verify_port_test;
    reg mclk = 1'b0;
    reg rst_n = 1'b0;
    reg prot = 1'b0;
    reg rdy = 1'b1;
    wire master_clear_pin, pclk, pdat, d_o, d_oe, mode, wv, busy;
    wire [13:0] wd, wa, ra;
    wire [13:0] rd = ra ^ 14'h15a5;
    integer errors = 0;
    integer checked = 0;
    integer i;
    reg [13:0] w;
    reg [13:0] n;
    initial begin
        forever #25 mclk = ~mclk;
    end
    spvp_top dut (.MCLK(mclk), .RST_N(rst_n), .MASTER_CLEAR_HIGH(master_clear_pin), .PROG_CLOCK_PIN(pclk),
        .PROG_DATA_PIN_I(pdat), .PROG_DATA_PIN_O(d_o), .PROG_DATA_PIN_OE(d_oe), .CODE_PROTECT(prot),
        .PROG_MODE(mode), .MEM_WR_VALID(wv), .MEM_WR_READY(rdy), .MEM_WR_DATA(wd), .MEM_WR_ADDR(wa),
        .MEM_RD_ADDR(ra), .MEM_RD_DATA(rd), .BUSY(busy));
    spvp_programmer prog (.mclk(mclk), .master_clear_pin_high(master_clear_pin), .prog_clk(pclk), .data_line(pdat),
        .dev_o(d_o), .dev_oe(d_oe));
    task chk(input string name, input [13:0] seen, input [13:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("wrong value %0s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task conclude;
        begin
            $display("checked %0d errors %0d", checked, errors);
            if (errors == 0 && checked > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task rd_chk(input string name, input [13:0] exp);
        begin
            prog.cmd(`SPVP_CMD_READ_DATA);
            prog.fetch(w);
            chk(name, w, exp);
        end
    endtask
    // Plain, protected and after an unknown command
    task t_read;
        begin
            prog.enter;
            chk("entry pc", ra, `SPVP_PC_RESET);
            rd_chk("word0", 14'h15a5);
            prog.cmd(`SPVP_CMD_INC_ADDR);
            prot <= 1'b1;
            rd_chk("protected", 14'h0000);
            prot <= 1'b0;
            prog.cmd(6'h3f);
            rd_chk("word1", 14'h15a4);
        end
    endtask
    // Upper bits of identification words read zero
    task t_id;
        begin
            prog.cmd(`SPVP_CMD_LOAD_CFG);
            prog.word(14'h3ffa);
            chk("id pc", ra, `SPVP_ID_BASE);
            prog.cmd(`SPVP_CMD_BEGIN_PROG);
            rd_chk("id0", 14'h000a);
            prog.cmd(`SPVP_CMD_INC_ADDR);
            prog.cmd(`SPVP_CMD_LOAD_DATA);
            prog.word(14'h2345);
            prog.cmd(`SPVP_CMD_BEGIN_PROG);
            rd_chk("id1", 14'h0005);
        end
    endtask
    // Seventeen words at rising addresses into a stalled memory, then drained in order
    task t_fill;
        begin
            prog.leave;
            chk("mode off", {13'h0000, mode}, 14'h0000);
            prog.enter;
            chk("pc again", ra, `SPVP_PC_RESET);
            rdy <= 1'b0;
            for (i = 0; i < 17; i = i + 1) begin
                prog.cmd(`SPVP_CMD_LOAD_DATA);
                prog.word(14'h0100 + i[13:0]);
                prog.cmd(`SPVP_CMD_BEGIN_PROG);
                prog.cmd(`SPVP_CMD_INC_ADDR);
            end
            repeat (4) @(posedge mclk);
            chk("busy full", {13'h0000, busy}, 14'h0001);
            rdy <= 1'b1;
            n = 14'h0000;
            repeat (60) begin
                @(posedge mclk);
                if (wv === 1'b1 && rdy === 1'b1) begin
                    chk("drain", wd, 14'h0100 + n);
                    n = n + 14'h0001;
                end
            end
            chk("pops", n, 14'h0011);
            chk("last addr", wa, 14'h0010);
        end
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk("reset oe", {13'h0000, d_oe}, 14'h0000);
        t_read;
        t_id;
        t_fill;
        conclude;
    end
    initial begin
        repeat (30000) @(posedge mclk);
        errors = errors + 1;
        conclude;
    end
endmodule // serial_program_verify_port_test

// >>> verification/spvp_assertions.sv
// Concurrent checks on the program/verify port, bound to spvp_top.
// Assumes every check runs on MCLK with RST_N synchronous and active low.
`timescale 1ns/1ps
`include "spvp_regs.vh"
module spvp_checker (
    // Clock and reset
    input wire MCLK,
    input wire RST_N,
    // Pins and mode
    input wire MASTER_CLEAR_HIGH,
    input wire CODE_PROTECT,
    input wire PROG_DATA_PIN_O,
    input wire PROG_DATA_PIN_OE,
    input wire PROG_MODE,
    // Memory side
    input wire MEM_WR_VALID,
    input wire MEM_WR_READY,
    input wire [13:0] MEM_WR_DATA,
    input wire [13:0] MEM_RD_ADDR,
    input wire BUSY
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    entry_pc_zero_a: assert property ($rose(PROG_MODE) |-> MEM_RD_ADDR == `SPVP_PC_RESET)
        else $error("pc not zero on entry");
    entry_needs_clear_a: assert property ($rose(PROG_MODE) |-> $past(MASTER_CLEAR_HIGH, 2))
        else $error("mode entered without master clear");
    clear_drop_exit_a: assert property (!MASTER_CLEAR_HIGH [*5] |-> !PROG_MODE)
        else $error("mode kept after master clear fell");
    drive_in_mode_a: assert property (PROG_DATA_PIN_OE |-> PROG_MODE)
        else $error("data driven outside mode");
    protect_blank_a: assert property (PROG_DATA_PIN_OE && CODE_PROTECT && MEM_RD_ADDR < `SPVP_ID_BASE
        |-> !PROG_DATA_PIN_O)
        else $error("protected memory read out");
    read_pc_steady_a: assert property (PROG_DATA_PIN_OE |=> $stable(MEM_RD_ADDR))
        else $error("pc moved during read");
    wr_hold_a: assert property (MEM_WR_VALID && !MEM_WR_READY |=> MEM_WR_VALID && $stable(MEM_WR_DATA))
        else $error("write word dropped while stalled");
    push_lands_a: assert property ($fell(BUSY) |-> ##[0:2] MEM_WR_VALID)
        else $error("program request left no word");
endmodule // spvp_checker
bind spvp_top spvp_checker chk (.MCLK, .RST_N, .MASTER_CLEAR_HIGH, .CODE_PROTECT, .PROG_DATA_PIN_O,
    .PROG_DATA_PIN_OE, .PROG_MODE, .MEM_WR_VALID, .MEM_WR_READY, .MEM_WR_DATA, .MEM_RD_ADDR, .BUSY);

// >>> verification/spvp_programmer.sv
// Behavioural serial programmer: master clear, link clock and data line.
// Assumes the device samples on falling link edges and answers after rising ones.
`timescale 1ns/1ps
module spvp_programmer (
    // Clock
    input wire mclk,
    // Pins
    output reg master_clear_pin_high = 1'b0,
    output reg prog_clk = 1'b0,
    output wire data_line,
    input wire dev_o,
    input wire dev_oe
);
    reg drv_en = 1'b1;
    reg drv = 1'b0;
    reg idle_r = 1'b0;
    // Released line toggles so a stale bit cannot pass
    always @(posedge mclk) idle_r <= ~idle_r;
    assign data_line = dev_oe ? dev_o : (drv_en ? drv : idle_r);
    task half;
        repeat (4) @(posedge mclk);
    endtask
    task enter;
        begin
            drv_en <= 1'b1;
            drv <= 1'b0;
            half;
            master_clear_pin_high <= 1'b1;
            half;
            half;
        end
    endtask
    task leave;
        begin
            master_clear_pin_high <= 1'b0;
            half;
        end
    endtask
    task send_bits(input [13:0] v, input integer n);
        integer i;
        begin
            drv_en <= 1'b1;
            for (i = 0; i < n; i = i + 1) begin
                prog_clk <= 1'b1;
                drv <= v[i];
                half;
                prog_clk <= 1'b0;
                half;
            end
        end
    endtask
    task cmd(input [5:0] c);
        send_bits({8'h00, c}, 6);
    endtask
    task word(input [13:0] v);
        send_bits(v, 14);
    endtask
    task fetch(output [13:0] w);
        integer i;
        begin
            drv_en <= 1'b0;
            for (i = 0; i < 14; i = i + 1) begin
                prog_clk <= 1'b1;
                half;
                prog_clk <= 1'b0;
                @(posedge mclk);
                w[i] = data_line;
                repeat (3) @(posedge mclk);
            end
        end
    endtask
endmodule // spvp_programmer
